// [verilog/lip_pkg.sv]
// Constants, carriers and helpers for the light and proximity interrupt logic.
// Assumes a register port fed by a serial-bus front end and conversion strobes from both sensor channels.
// Overview of operation
// - Light result below low limit or above high limit is out of range.
// - Proximity result below low limit or above high limit is out of range.
// - Each sensor counts consecutive out-of-range results (light code 00 counts any result); flag rises at persistence count.
// - Raised interrupt holds until host writes zero to its flag bit in the interrupt configuration register.
// - Combine bit one: pin asserts only while both flags are set.
// - Combine bit resets to zero; zero asserts pin when either flag is set.
// - Clearing both enable bits powers down; both measurements stop.
// - Range codes 0 to 3 step finer scales; codes 4 to 7 finest.
// - Proximity persistence codes give 1, 4, 8 or 16 tripping conversions.
// - Light persistence code 00 flags every cycle; others need 4, 8, 16.
// - Light flag reads zero until an event, one after; written zero clears.
// - Interrupt pin is active low, driven while selected flag combination holds.
package lip_pkg;

	localparam int LIP_LIGHT_W = 12;
	localparam int LIP_PROX_W = 8;
	localparam int LIP_CNT_W = 5;

	// Register offsets
	localparam logic [7:0] LIP_OFS_ENABLE = 8'h01;
	localparam logic [7:0] LIP_OFS_INTCFG = 8'h02;
	localparam logic [7:0] LIP_OFS_PROX_LOW = 8'h03;
	localparam logic [7:0] LIP_OFS_PROX_HIGH = 8'h04;
	localparam logic [7:0] LIP_OFS_LTH1 = 8'h05;
	localparam logic [7:0] LIP_OFS_LTH2 = 8'h06;
	localparam logic [7:0] LIP_OFS_LTH3 = 8'h07;
	localparam logic [7:0] LIP_OFS_PROX_DATA = 8'h08;
	localparam logic [7:0] LIP_OFS_LDATA1 = 8'h09;
	localparam logic [7:0] LIP_OFS_LDATA2 = 8'h0a;
	localparam logic [7:0] LIP_OFS_RANGE = 8'h0b;

	// Field positions
	localparam int LIP_BIT_LIGHT_EN = 0;
	localparam int LIP_BIT_PROX_EN = 1;
	localparam int LIP_BIT_COMBINE = 0;
	localparam int LIP_BIT_LPERS_LO = 1;
	localparam int LIP_BIT_LFLAG = 3;
	localparam int LIP_BIT_PPERS_LO = 5;
	localparam int LIP_BIT_PFLAG = 7;

	// Reset values and finest scale code
	localparam logic [7:0] LIP_RST_ENABLE = 8'h00;
	localparam logic [7:0] LIP_RST_INTCFG = 8'h00;
	localparam logic [7:0] LIP_RST_LIMIT = 8'h00;
	localparam logic [7:0] LIP_RST_HIGH = 8'hff;
	localparam logic [7:0] LIP_RST_RANGE = 8'h00;
	localparam logic [2:0] LIP_SCALE_FINEST = 3'h4;

	// Persistence counts
	localparam logic [LIP_CNT_W-1:0] LIP_NEED_0 = 5'h01;
	localparam logic [LIP_CNT_W-1:0] LIP_NEED_1 = 5'h04;
	localparam logic [LIP_CNT_W-1:0] LIP_NEED_2 = 5'h08;
	localparam logic [LIP_CNT_W-1:0] LIP_NEED_3 = 5'h10;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lip_reg_req_s;

	typedef struct packed {
		logic done;
		logic [LIP_LIGHT_W-1:0] data;
	} lip_light_conv_s;

	typedef struct packed {
		logic done;
		logic [LIP_PROX_W-1:0] data;
	} lip_prox_conv_s;

	function automatic logic [LIP_CNT_W-1:0] lip_persist_need(input logic [1:0] code);
		case (code)
			2'h0: lip_persist_need = LIP_NEED_0;
			2'h1: lip_persist_need = LIP_NEED_1;
			2'h2: lip_persist_need = LIP_NEED_2;
			default: lip_persist_need = LIP_NEED_3;
		endcase
	endfunction : lip_persist_need

endpackage : lip_pkg

// [verilog/lip_persist_filter.sv]
// Window compare and persistence filter for one sensor channel.
// Assumes conv_done_in is a one-cycle strobe already gated by the channel enable.
`timescale 1ns/1ps
module lip_persist_filter #(
	parameter int RES_W = 12,
	parameter bit CODE0_ALWAYS = 1'h0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic conv_done_in,
	input wire logic [RES_W-1:0] result_in,
	input wire logic [RES_W-1:0] low_in,
	input wire logic [RES_W-1:0] high_in,
	input wire logic [1:0] persist_in,
	input wire logic flag_clear_in,
	output logic flag_out,
	output logic [lip_pkg::LIP_CNT_W-1:0] count_out
);
	import lip_pkg::*;

	logic flag_r, flag_nxt;
	logic [LIP_CNT_W-1:0] count_r, count_nxt, need;
	logic outside;

	always_comb begin
		need = lip_persist_need(persist_in);
		outside = (result_in < low_in) || (result_in > high_in);
		count_nxt = count_r;
		flag_nxt = flag_r;
		if (flag_clear_in) begin
			flag_nxt = 1'h0;
		end
		// Set is applied after clear so an event in the clearing cycle survives
		if (conv_done_in) begin
			if (outside || (CODE0_ALWAYS && persist_in == 2'h0)) begin
				if (count_r + 5'h01 >= need) begin
					count_nxt = need;
					flag_nxt = 1'h1;
				end else begin
					count_nxt = count_r + 5'h01;
				end
			end else begin
				count_nxt = '0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			flag_r <= 1'h0;
			count_r <= '0;
		end else begin
			flag_r <= flag_nxt;
			count_r <= count_nxt;
		end
	end

	assign flag_out = flag_r;
	assign count_out = count_r;

	a_count_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		count_r <= LIP_NEED_3)
		else $error("persistence count above sixteen");

endmodule : lip_persist_filter

// [verilog/lip_interrupt_logic.sv]
// Register file and interrupt generation for the light and proximity sensor.
// Assumes a serial-bus front end presents one-cycle register writes and samples read data a cycle after the address.
`timescale 1ns/1ps
module lip_interrupt_logic (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire lip_pkg::lip_reg_req_s reg_req_in,
	output logic [7:0] reg_rdata_out,
	input wire lip_pkg::lip_light_conv_s light_conv_in,
	input wire lip_pkg::lip_prox_conv_s prox_conv_in,
	output logic light_enable_out,
	output logic proximity_enable_out,
	output logic power_down_out,
	output logic [2:0] light_scale_select_out,
	output logic interrupt_out_low_out,
	output logic interrupt_oe_out
);
	import lip_pkg::*;

	logic [7:0] enable_r, enable_nxt;
	logic [7:0] intcfg_r, intcfg_nxt;
	logic [7:0] plow_r, plow_nxt, phigh_r, phigh_nxt;
	logic [7:0] lth1_r, lth1_nxt, lth2_r, lth2_nxt, lth3_r, lth3_nxt;
	logic [7:0] range_r, range_nxt;
	logic [LIP_PROX_W-1:0] pdata_r, pdata_nxt;
	logic [LIP_LIGHT_W-1:0] ldata_r, ldata_nxt;
	logic [7:0] rdata_nxt;
	logic l_en_r, l_en_nxt, p_en_r, p_en_nxt, pd_r, pd_nxt;
	logic [2:0] scale_r, scale_nxt;
	logic int_oe_r, int_oe_nxt, pin_r, pin_nxt;
	logic wr_intcfg, l_done, p_done, l_flag, p_flag, hit;
	logic [LIP_LIGHT_W-1:0] l_low, l_high;
	logic [LIP_CNT_W-1:0] l_count, p_count;

	function automatic logic [2:0] scale_decode(input logic [2:0] code);
		scale_decode = (code >= LIP_SCALE_FINEST) ? LIP_SCALE_FINEST : code;
	endfunction : scale_decode

	// Register writes
	always_comb begin
		enable_nxt = enable_r;
		intcfg_nxt = intcfg_r;
		plow_nxt = plow_r;
		phigh_nxt = phigh_r;
		lth1_nxt = lth1_r;
		lth2_nxt = lth2_r;
		lth3_nxt = lth3_r;
		range_nxt = range_r;
		if (reg_req_in.wr) begin
			if (reg_req_in.addr == LIP_OFS_ENABLE) begin
				enable_nxt = reg_req_in.wdata;
			end else if (reg_req_in.addr == LIP_OFS_INTCFG) begin
				// Flag bits live in the filters; only control fields are stored here
				intcfg_nxt = reg_req_in.wdata & 8'h67;
			end else if (reg_req_in.addr == LIP_OFS_PROX_LOW) begin
				plow_nxt = reg_req_in.wdata;
			end else if (reg_req_in.addr == LIP_OFS_PROX_HIGH) begin
				phigh_nxt = reg_req_in.wdata;
			end else if (reg_req_in.addr == LIP_OFS_LTH1) begin
				lth1_nxt = reg_req_in.wdata;
			end else if (reg_req_in.addr == LIP_OFS_LTH2) begin
				lth2_nxt = reg_req_in.wdata;
			end else if (reg_req_in.addr == LIP_OFS_LTH3) begin
				lth3_nxt = reg_req_in.wdata;
			end else if (reg_req_in.addr == LIP_OFS_RANGE) begin
				range_nxt = {5'h00, reg_req_in.wdata[2:0]};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			enable_r <= LIP_RST_ENABLE;
			intcfg_r <= LIP_RST_INTCFG;
			plow_r <= LIP_RST_LIMIT;
			phigh_r <= LIP_RST_HIGH;
			lth1_r <= LIP_RST_LIMIT;
			lth2_r <= LIP_RST_HIGH & 8'hf0;
			lth3_r <= LIP_RST_HIGH;
			range_r <= LIP_RST_RANGE;
		end else begin
			enable_r <= enable_nxt;
			intcfg_r <= intcfg_nxt;
			plow_r <= plow_nxt;
			phigh_r <= phigh_nxt;
			lth1_r <= lth1_nxt;
			lth2_r <= lth2_nxt;
			lth3_r <= lth3_nxt;
			range_r <= range_nxt;
		end
	end

	// Conversions are ignored while a channel is disabled
	assign l_done = light_conv_in.done && enable_r[LIP_BIT_LIGHT_EN];
	assign p_done = prox_conv_in.done && enable_r[LIP_BIT_PROX_EN];
	assign wr_intcfg = reg_req_in.wr && (reg_req_in.addr == LIP_OFS_INTCFG);
	assign l_low = {lth2_r[3:0], lth1_r};
	assign l_high = {lth3_r, lth2_r[7:4]};

	lip_persist_filter #(
		.RES_W(LIP_LIGHT_W),
		.CODE0_ALWAYS(1'h1)
	) u_light_filter (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.conv_done_in(l_done),
		.result_in(light_conv_in.data),
		.low_in(l_low),
		.high_in(l_high),
		.persist_in(intcfg_r[LIP_BIT_LPERS_LO+:2]),
		.flag_clear_in(wr_intcfg && !reg_req_in.wdata[LIP_BIT_LFLAG]),
		.flag_out(l_flag),
		.count_out(l_count)
	);

	lip_persist_filter #(
		.RES_W(LIP_PROX_W),
		.CODE0_ALWAYS(1'h0)
	) u_prox_filter (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.conv_done_in(p_done),
		.result_in(prox_conv_in.data),
		.low_in(plow_r),
		.high_in(phigh_r),
		.persist_in(intcfg_r[LIP_BIT_PPERS_LO+:2]),
		.flag_clear_in(wr_intcfg && !reg_req_in.wdata[LIP_BIT_PFLAG]),
		.flag_out(p_flag),
		.count_out(p_count)
	);

	// Status, read-back and pin
	always_comb begin
		pdata_nxt = p_done ? prox_conv_in.data : pdata_r;
		ldata_nxt = l_done ? light_conv_in.data : ldata_r;
		if (intcfg_r[LIP_BIT_COMBINE]) begin
			hit = l_flag && p_flag;
		end else begin
			hit = l_flag || p_flag;
		end
		int_oe_nxt = hit;
		pin_nxt = !hit;
		l_en_nxt = enable_r[LIP_BIT_LIGHT_EN];
		p_en_nxt = enable_r[LIP_BIT_PROX_EN];
		pd_nxt = !enable_r[LIP_BIT_LIGHT_EN] && !enable_r[LIP_BIT_PROX_EN];
		scale_nxt = scale_decode(range_r[2:0]);
		if (reg_req_in.addr == LIP_OFS_ENABLE) begin
			rdata_nxt = enable_r;
		end else if (reg_req_in.addr == LIP_OFS_INTCFG) begin
			rdata_nxt = intcfg_r | {p_flag, 3'h0, l_flag, 3'h0};
		end else if (reg_req_in.addr == LIP_OFS_PROX_LOW) begin
			rdata_nxt = plow_r;
		end else if (reg_req_in.addr == LIP_OFS_PROX_HIGH) begin
			rdata_nxt = phigh_r;
		end else if (reg_req_in.addr == LIP_OFS_LTH1) begin
			rdata_nxt = lth1_r;
		end else if (reg_req_in.addr == LIP_OFS_LTH2) begin
			rdata_nxt = lth2_r;
		end else if (reg_req_in.addr == LIP_OFS_LTH3) begin
			rdata_nxt = lth3_r;
		end else if (reg_req_in.addr == LIP_OFS_PROX_DATA) begin
			rdata_nxt = pdata_r;
		end else if (reg_req_in.addr == LIP_OFS_LDATA1) begin
			rdata_nxt = ldata_r[7:0];
		end else if (reg_req_in.addr == LIP_OFS_LDATA2) begin
			rdata_nxt = {4'h0, ldata_r[11:8]};
		end else if (reg_req_in.addr == LIP_OFS_RANGE) begin
			rdata_nxt = range_r;
		end else begin
			rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pdata_r <= '0;
			ldata_r <= '0;
			int_oe_r <= 1'h0;
			pin_r <= 1'h1;
			l_en_r <= 1'h0;
			p_en_r <= 1'h0;
			pd_r <= 1'h1;
			scale_r <= 3'h0;
			reg_rdata_out <= 8'h00;
		end else begin
			pdata_r <= pdata_nxt;
			ldata_r <= ldata_nxt;
			int_oe_r <= int_oe_nxt;
			pin_r <= pin_nxt;
			l_en_r <= l_en_nxt;
			p_en_r <= p_en_nxt;
			pd_r <= pd_nxt;
			scale_r <= scale_nxt;
			reg_rdata_out <= rdata_nxt;
		end
	end

	assign interrupt_oe_out = int_oe_r;
	assign interrupt_out_low_out = pin_r;
	assign light_enable_out = l_en_r;
	assign proximity_enable_out = p_en_r;
	assign power_down_out = pd_r;
	assign light_scale_select_out = scale_r;

	a_light_out_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(l_done && light_conv_in.data > l_high && intcfg_r[2:1] == 2'h0) |=> l_flag)
		else $error("light result above high limit did not flag");

	a_prox_out_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(p_done && prox_conv_in.data < plow_r && intcfg_r[6:5] == 2'h0) |=> p_flag)
		else $error("proximity result below low limit did not flag");

	a_prox_equal_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(p_done && prox_conv_in.data == plow_r && plow_r <= phigh_r && !p_flag && !wr_intcfg) |=> !p_flag)
		else $error("proximity result on limit raised the flag");

	a_flag_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(p_flag && !wr_intcfg) |=> p_flag)
		else $error("proximity flag dropped without a write");

	a_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_intcfg && !reg_req_in.wdata[LIP_BIT_LFLAG] && !l_done) |=> !l_flag)
		else $error("light flag not cleared by write of zero");

	a_stop_light: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!enable_r[LIP_BIT_LIGHT_EN] && !l_flag) |=> !l_flag)
		else $error("light flag rose while light channel disabled");

	a_pin_or: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!intcfg_r[LIP_BIT_COMBINE] && (l_flag || p_flag)) |=> (interrupt_oe_out && !interrupt_out_low_out))
		else $error("pin not asserted in either-flag mode");

	a_pin_and: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(intcfg_r[LIP_BIT_COMBINE] && !(l_flag && p_flag)) |=> !interrupt_oe_out)
		else $error("pin asserted without both flags");

	a_scale_finest: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(range_r[2]) |=> light_scale_select_out == LIP_SCALE_FINEST)
		else $error("upper range codes not mapped to finest scale");

	a_prox_persist4: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(p_done && !p_flag && p_count == 5'h00 && intcfg_r[6:5] == 2'h1) |=> !p_flag)
		else $error("proximity flag rose on first of four");

	// First out-of-window result under code 01 must not flag yet
	a_light_persist4: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(l_done && !l_flag && l_count == 5'h00 && intcfg_r[2:1] == 2'h1) |=> !l_flag)
		else $error("light flag rose on first of four");

	c_light_event: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(l_flag));
	c_and_assert: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		intcfg_r[LIP_BIT_COMBINE] && $rose(interrupt_oe_out));
	c_prox_sixteen: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(p_flag) && intcfg_r[6:5] == 2'h3);
	c_clear_write: cover property (@(posedge clk_in) disable iff (!rst_n_in) $fell(interrupt_oe_out));

endmodule : lip_interrupt_logic

// [verification/lip_host_model.sv]
// Host model: register writes and reads, and the pulled-up interrupt line.
// Assumes one-cycle write strobes and read data one cycle after the address.
`timescale 1ns/1ps
module lip_host_model (
	input wire logic clk_in,
	output lip_pkg::lip_reg_req_s req_out,
	input wire logic [7:0] rdata_in,
	input wire logic pin_low_in,
	input wire logic oe_in,
	output logic line_out
);
	import lip_pkg::*;
	// Open drain with pull-up: the line is high unless the device drives it
	assign line_out = oe_in ? pin_low_in : 1'h1;
	initial req_out = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{1'h1, a, d};
		@(posedge clk_in);
		req_out <= '{1'h0, a, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req_out.addr <= a;
		@(posedge clk_in);
		#1 d = rdata_in;
	endtask : rd
endmodule : lip_host_model

// [verification/lip_interrupt_logic_tb_top.sv]
// Self-checking bench for the light and proximity interrupt logic.
// Assumes the host model drives the register port; conversions come from the bench.
`timescale 1ns/1ps
module lip_interrupt_logic_tb_top;
	import lip_pkg::*;
	logic clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	lip_reg_req_s req;
	logic [7:0] rdata;
	lip_light_conv_s lconv = '0;
	lip_prox_conv_s pconv = '0;
	logic len, pen, pdn, pin_low, oe, line;
	logic [2:0] scale;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	initial forever #25 clk_in = ~clk_in;
	lip_interrupt_logic DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
		.light_conv_in(lconv), .prox_conv_in(pconv), .light_enable_out(len), .proximity_enable_out(pen),
		.power_down_out(pdn), .light_scale_select_out(scale), .interrupt_out_low_out(pin_low),
		.interrupt_oe_out(oe));
	lip_host_model host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .pin_low_in(pin_low),
		.oe_in(oe), .line_out(line));
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		host.rd(a, v);
		check(what, v & m, e);
	endtask : rchk
	// Back-to-back strobes; data is scrambled on release so stale values never pass
	task automatic conv(input bit lt, input int n, input logic [11:0] d);
		repeat (n) begin
			@(posedge clk_in);
			if (lt) lconv <= '{1'h1, d};
			else pconv <= '{1'h1, d[7:0]};
		end
		@(posedge clk_in);
		if (lt) lconv <= '{1'h0, ~d};
		else pconv <= '{1'h0, ~d[7:0]};
	endtask : conv
	task automatic t_reset();
		rchk("enable", 8'h01, 8'hff, 8'h00);
		rchk("intcfg", 8'h02, 8'hff, 8'h00);
		rchk("range", 8'h0b, 8'hff, 8'h00);
		check("line", line, 1'h1);
		check("oe", oe, 1'h0);
		check("pdn", pdn, 1'h1);
	endtask : t_reset
	task automatic t_prox();
		int need;
		host.wr(8'h01, 8'h02);
		host.wr(8'h03, 8'h0a);
		host.wr(8'h04, 8'h14);
		for (int c = 0; c < 4; c++) begin
			need = (c == 0) ? 1 : 4 << (c - 1);
			host.wr(8'h02, 8'(c << 5));
			// A result on a limit resets any count left from the last code
			conv(0, 1, 12'h00a);
			conv(0, need - 1, 12'h005);
			conv(0, 1, 12'h014);
			conv(0, need - 1, 12'h015);
			rchk("pflag early", 8'h02, 8'h80, 8'h00);
			check("line", line, 1'h1);
			conv(0, 1, 12'h0ff);
			rchk("pflag", 8'h02, 8'h80, 8'h80);
			check("line", line, 1'h0);
			check("oe", oe, 1'h1);
		end
		conv(0, 2, 12'h00f);
		host.wr(8'h02, 8'he0);
		rchk("pflag hold", 8'h02, 8'h80, 8'h80);
		host.wr(8'h02, 8'h60);
		rchk("cfg", 8'h02, 8'he7, 8'h60);
		check("line", line, 1'h1);
	endtask : t_prox
	task automatic t_light();
		host.wr(8'h01, 8'h03);
		host.wr(8'h05, 8'h00);
		host.wr(8'h06, 8'h01);
		host.wr(8'h07, 8'h20);
		host.wr(8'h02, 8'h00);
		conv(1, 1, 12'h150);
		rchk("lflag any", 8'h02, 8'h08, 8'h08);
		rchk("ldata lo", 8'h09, 8'hff, 8'h50);
		rchk("ldata hi", 8'h0a, 8'hff, 8'h01);
		check("len", len, 1'h1);
		check("pen", pen, 1'h1);
		check("pdn", pdn, 1'h0);
		host.wr(8'h02, 8'h02);
		conv(1, 1, 12'h100);
		conv(1, 3, 12'h201);
		conv(1, 1, 12'h200);
		conv(1, 3, 12'h0ff);
		rchk("lflag early", 8'h02, 8'h08, 8'h00);
		conv(1, 1, 12'h0ff);
		rchk("lflag", 8'h02, 8'h08, 8'h08);
	endtask : t_light
	task automatic t_combine();
		host.wr(8'h02, 8'h01);
		conv(1, 1, 12'h150);
		rchk("flags l", 8'h02, 8'h88, 8'h08);
		check("line and", line, 1'h1);
		conv(0, 1, 12'h0ff);
		rchk("flags lp", 8'h02, 8'h88, 8'h88);
		check("line and", line, 1'h0);
		host.wr(8'h02, 8'h81);
		rchk("flags p", 8'h02, 8'h88, 8'h80);
		check("line and", line, 1'h1);
		host.wr(8'h02, 8'h80);
		rchk("flags p", 8'h02, 8'h88, 8'h80);
		check("line or", line, 1'h0);
	endtask : t_combine
	task automatic t_power();
		host.wr(8'h02, 8'h00);
		host.wr(8'h01, 8'h00);
		conv(0, 1, 12'h005);
		conv(1, 1, 12'h0ff);
		rchk("flags off", 8'h02, 8'h88, 8'h00);
		check("pdn", pdn, 1'h1);
		check("len", len, 1'h0);
		check("pen", pen, 1'h0);
		check("line", line, 1'h1);
		host.wr(8'h08, 8'h33);
		rchk("pdata", 8'h08, 8'hff, 8'hff);
		rchk("unmapped", 8'h0c, 8'hff, 8'h00);
	endtask : t_power
	task automatic t_range();
		for (int c = 0; c < 8; c++) begin
			host.wr(8'h0b, 8'hf8 | 8'(c));
			rchk("range", 8'h0b, 8'hff, 8'(c));
			check("scale", scale, (c < 4) ? 12'(c) : 12'h004);
		end
	endtask : t_range
	task automatic tally_and_finish();
		if (n_fail == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// Whole run needs about 240 cycles; the ceiling leaves wide margin
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'h1;
		t_reset();
		t_prox();
		t_light();
		t_combine();
		t_power();
		t_range();
		tally_and_finish();
	end
endmodule : lip_interrupt_logic_tb_top
